// File: rtl/ptd_delay_stage.sv
// Pump turn-on delay stage: enables the pump a fixed time after detection
`timescale 1ns/1ps
`include "ptd_params.svh"
`default_nettype none
module ptd_delay_stage
    import ptd_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = `PTD_DELAY_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire ptd_det_t detIn,
    output logic pumpEnable
);
    localparam logic [`PTD_DLY_W-1:0] LAST = DELAY_CYCLES[`PTD_DLY_W-1:0] - 32'h0000_0001;

    ptd_state_t state;
    ptd_state_t next_state;
    logic [`PTD_DLY_W-1:0] count;
    logic [`PTD_DLY_W-1:0] next_count;

    ////////////////////////////////////////////////////////////////////////
    // Next state: a low detector always drops the pump and clears the count
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            PTD_WAIT: begin
                next_count = `PTD_DLY_RST;
                if (detIn.level) begin
                    next_state = (LAST == `PTD_DLY_RST) ? PTD_RUN : PTD_COUNT;
                    next_count = 32'h0000_0001;
                end
            end
            PTD_COUNT: begin
                if (!detIn.level) begin
                    next_state = PTD_WAIT;
                    next_count = `PTD_DLY_RST;
                end else if (count == LAST) begin
                    next_state = PTD_RUN;
                end else begin
                    next_count = count + 32'h0000_0001;
                end
            end
            PTD_RUN: begin
                if (!detIn.level) begin
                    next_state = PTD_WAIT;
                    next_count = `PTD_DLY_RST;
                end
            end
            default: begin
                next_state = PTD_WAIT;
                next_count = `PTD_DLY_RST;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= PTD_WAIT;
            count <= `PTD_DLY_RST;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Output decoded from state only, so it is glitch free toward the pump driver
    assign pumpEnable = (state == PTD_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    delay_exact_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pumpEnable) |-> $past(count) == LAST && $past(detIn.level))
        else $error("pump enabled at wrong delay count");
    drop_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
        !detIn.level |=> !pumpEnable && count == `PTD_DLY_RST)
        else $error("pump not dropped or count not cleared");
    count_steps_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == PTD_COUNT && detIn.level && count != LAST) |=> count == $past(count) + 1)
        else $error("delay count did not advance");
    // The level only rises on the edge flag that travels with it
    level_after_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(detIn.level) |-> $past(detIn.edgeSeen))
        else $error("detector level rose without a primary input edge");
endmodule
`default_nettype wire

// File: rtl/ptd_params.svh
// Timing constants for the pump turn-on control block
`ifndef PTD_PARAMS_SVH
`define PTD_PARAMS_SVH

// Logic clock rate in hertz
`define PTD_CLK_HZ 10000000
// Pump delay time in seconds
`define PTD_DELAY_S 60
// Pump delay in clock cycles
`define PTD_DELAY_CYC (`PTD_DELAY_S * `PTD_CLK_HZ)
// Turn-on threshold frequency in hertz, well above the zero conductivity frequency
`define PTD_THRESH_HZ 3250
// Shortest period, in cycles, counted as below threshold (rounded down)
`define PTD_THRESH_CYC (`PTD_CLK_HZ / `PTD_THRESH_HZ)
// Period counter width
`define PTD_PER_W 16
// Delay counter width
`define PTD_DLY_W 32
// Reset values; the period count starts saturated at the threshold count,
// so the first edge after reset is judged to end a slow period
`define PTD_PER_RST 16'h0C04
`define PTD_DLY_RST 32'h0000_0000

`endif

// File: rtl/ptd_pkg.sv
// Types shared by the pump turn-on control block
`default_nettype none
package ptd_pkg;
    // Detector result carried from the counter stage to the delay stage
    typedef struct packed {
        logic level;
        logic edgeSeen;
    } ptd_det_t;

    // Delay stage states
    typedef enum logic [1:0] {
        PTD_WAIT,
        PTD_COUNT,
        PTD_RUN
    } ptd_state_t;
endpackage
`default_nettype wire

// File: rtl/ptd_pump_turn_on.sv
// Pump turn-on control: conductivity frequency detector and delayed pump enable
//
// Operation
// - The pump decision is taken only from the primary conductivity input.
// - The turn-on threshold sits well above the zero conductivity frequency.
// - The pump is enabled only after detection and then the full delay, in that order.
// - The detector reads low near 2500 Hz and high near 4000 Hz.
// - The detector level feeds the delay stage unchanged.
// - The pump enable rises exactly 60 seconds after the detector goes high.
//
// Timing, counted in logic clock edges:
// - a pin rise is in the second sync flop two edges later, and the edge
//   detector fires while that flop is high and the third is still low;
// - on that edge the period count restarts at one, so at the next rise it
//   holds the number of clocks between the two rises;
// - the detector register takes its new level on the edge that sees the rise;
// - the delay stage starts counting on the edge after the detector goes
//   high and raises the pump enable the full delay count of edges after
//   the detector rose;
// - a low detector stops the pump and clears the delay on the next edge.
// The threshold sits between the slow and the fast test tones, far above a
// cell in air, and a dead input saturates the period count, so the flag
// falls a threshold period after the last edge.
// Limitation: pin pulses shorter than about one clock may be missed by the
// synchroniser; sensor tones are thousands of clocks long, so this is safe.
`timescale 1ns/1ps
`include "ptd_params.svh"
`default_nettype none
module ptd_pump_turn_on
    import ptd_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = `PTD_DELAY_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic condPrimary,
    output logic freqDetect,
    output logic pumpEnable
);
    // Period count at which a tone is judged too slow, cut to the counter width
    localparam logic [`PTD_PER_W-1:0] THRESH = 16'(`PTD_THRESH_CYC);
    // Pump delay in clocks, as used by the independent check counter
    localparam logic [`PTD_DLY_W-1:0] DLY_TARGET = DELAY_CYCLES[`PTD_DLY_W-1:0];

    logic condSync1;
    logic condSync2;
    logic condPrev;
    logic condRise;
    logic [`PTD_PER_W-1:0] periodCount;
    logic [`PTD_PER_W-1:0] next_periodCount;
    logic next_freqDetect;
    ptd_det_t detBus;
    // Check helper state, read only by the assertions
    logic [`PTD_DLY_W-1:0] detAge;
    logic [`PTD_DLY_W-1:0] next_detAge;

    ////////////////////////////////////////////////////////////////////////
    // Squared input comes from outside the clock domain: two flops first
    // Only the second flop reads the first; the third just remembers the
    // previous synchronised level for the edge detector.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            condSync1 <= 1'b0;
            condSync2 <= 1'b0;
            condPrev <= 1'b0;
        end else begin
            condSync1 <= condPrimary;
            condSync2 <= condSync1;
            condPrev <= condSync2;
        end
    end

    // Rising edge of the synchronised input starts each period
    assign condRise = condSync2 && !condPrev;

    ////////////////////////////////////////////////////////////////////////
    // Retriggerable one-shot: each rising edge restarts the period count.
    // An edge arriving before the count reaches the threshold means the
    // frequency is above turn-on; the count saturating means it is below.
    // Saturating also covers a dead input, so a dry cell never turns on.
    // The reset value is the saturated count, so a lone edge right after
    // reset is treated as ending a slow period and cannot raise the flag.
    always_comb begin
        next_periodCount = periodCount;
        next_freqDetect = freqDetect;
        if (condRise) begin
            next_periodCount = 16'h0001;
            next_freqDetect = (periodCount < THRESH);
        end else if (periodCount >= THRESH) begin
            next_periodCount = THRESH;
            next_freqDetect = 1'b0;
        end else begin
            next_periodCount = periodCount + 16'h0001;
        end
    end

    // Detector registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            periodCount <= `PTD_PER_RST;
            freqDetect <= 1'b0;
        end else begin
            periodCount <= next_periodCount;
            freqDetect <= next_freqDetect;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detector level handed on as is; edge flag rides along for observers
    assign detBus.level = freqDetect;
    assign detBus.edgeSeen = condRise;

    // Fixed pump delay stage
    ptd_delay_stage #(
        .DELAY_CYCLES(DELAY_CYCLES)
    ) delayStage (
        .ref_clk(ref_clk),
        .rst(rst),
        .detIn(detBus),
        .pumpEnable(pumpEnable)
    );

    ////////////////////////////////////////////////////////////////////////
    // Check helper: how long the detector has stood high, counted apart
    // from the delay stage so the pump timing is judged by a second counter.
    // It saturates at the delay, so a long pumping run never wraps it, and
    // nothing but the checks reads it, so synthesis trims it away.
    always_comb begin
        next_detAge = detAge;
        if (!freqDetect) begin
            next_detAge = `PTD_DLY_RST;
        end else if (detAge != DLY_TARGET) begin
            next_detAge = detAge + 32'h0000_0001;
        end
    end

    // Helper register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            detAge <= `PTD_DLY_RST;
        end else begin
            detAge <= next_detAge;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the detector; all run on the logic clock and are held off
    // while reset is high, so nothing is judged until reset falls.

    // A change of level needs a primary edge or a saturated period
    source_only_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(freqDetect) |-> $past(condRise) || $past(periodCount) >= THRESH)
        else $error("detector changed without a primary input cause");

    // No edge, no rise: drift on a dead input cannot raise the flag
    low_keeps_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!freqDetect && !condRise) |=> !freqDetect)
        else $error("detector rose without an input edge");

    // A saturated count means a slow tone or none
    slow_is_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (periodCount >= THRESH && !condRise) |=> !freqDetect)
        else $error("detector high below threshold frequency");

    // The count never passes its saturation point
    period_cap_a: assert property (@(posedge ref_clk) disable iff (rst)
        periodCount <= THRESH)
        else $error("period count passed its ceiling");

    // Each edge restarts the period count
    rise_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
        condRise |=> periodCount == 16'h0001)
        else $error("period count not restarted by an edge");

    // A short period reads high
    fast_is_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        (condRise && periodCount < THRESH) |=> freqDetect)
        else $error("detector low above threshold frequency");

    // A long period reads low
    slow_edge_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (condRise && periodCount >= THRESH) |=> !freqDetect)
        else $error("detector high after a long period");

    // Between edges a high level stands until the count saturates
    det_stands_a: assert property (@(posedge ref_clk) disable iff (rst)
        (freqDetect && !condRise && periodCount < THRESH) |=> freqDetect)
        else $error("detector dropped inside a fast period");

    ////////////////////////////////////////////////////////////////////////
    // Checks on the pump enable, partly against the helper counter

    // The pump rises only after the detector has been high
    pump_needs_det_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pumpEnable) |-> $past(freqDetect))
        else $error("pump enabled without prior detection");

    // The pump is never on before the detector has stood the full delay
    pump_age_a: assert property (@(posedge ref_clk) disable iff (rst)
        pumpEnable |-> detAge == DLY_TARGET)
        else $error("pump on before the full delay");

    // Once the detector has stood the full delay the pump is on
    age_pump_on_a: assert property (@(posedge ref_clk) disable iff (rst)
        (freqDetect && detAge == DLY_TARGET) |-> pumpEnable)
        else $error("pump late after the full delay");

    // A high detector keeps a running pump on
    pump_holds_a: assert property (@(posedge ref_clk) disable iff (rst)
        (pumpEnable && freqDetect) |=> pumpEnable)
        else $error("pump dropped while detector high");

    // A falling detector stops the pump on the next edge
    det_drop_pump_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(freqDetect) |=> !pumpEnable)
        else $error("pump stayed on after detector fell");

    // The pump only runs if the detector was high on the edge before
    pump_follows_a: assert property (@(posedge ref_clk) disable iff (rst)
        pumpEnable |-> $past(freqDetect))
        else $error("pump on while detector was low");
endmodule
`default_nettype wire

// File: tb/ptd_cond_source.sv
// Squared primary conductivity sensor model
`timescale 1ns/1ps
`default_nettype none
module ptd_cond_source (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic [15:0] halfCycles,
    output logic condOut
);
    logic [15:0] phase;
    initial begin
        condOut = 1'b0;
        phase = 16'h0000;
    end
    // Tone counted in logic clocks; a sensor in air rests low, so no stale edges
    always @(posedge ref_clk) begin
        if (!run) begin
            condOut <= 1'b0;
            phase <= 16'h0000;
        end else if (phase >= halfCycles - 16'h0001) begin
            condOut <= !condOut;
            phase <= 16'h0000;
        end else begin
            phase <= phase + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_ptd_pump_turn_on.sv
// Self-checking bench for the pump turn-on control block
`timescale 1ns/1ps
`default_nettype none
module tb_ptd_pump_turn_on;
    // Delay longer than a threshold period, so a drop before expiry is reachable
    localparam int DLY = 5000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic [15:0] halfCycles = 16'h07D0;
    logic condPrimary;
    logic freqDetect;
    logic pumpEnable;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    ptd_cond_source i_src (.ref_clk(ref_clk), .run(run), .halfCycles(halfCycles),
        .condOut(condPrimary));
    ptd_pump_turn_on #(.DELAY_CYCLES(DLY)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .condPrimary(condPrimary), .freqDetect(freqDetect), .pumpEnable(pumpEnable));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #50 ref_clk = !ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Sample one time unit after the edge so its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_det(input logic lvl, input int lim);
        int n;
        n = 0;
        while (freqDetect !== lvl && n < lim) begin
            tick(1);
            n++;
        end
        check("detect_level", freqDetect, lvl);
    endtask
    // Counts edges from detector high to pump high; the count must be the full delay
    task automatic measure_delay();
        int n;
        wait_det(1'b1, 6000);
        n = 0;
        while (pumpEnable !== 1'b1 && n < DLY + 10) begin
            tick(1);
            n++;
        end
        check("pump_delay", n, DLY);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    // Watched from the first edge on, so a lone first edge after reset cannot read high
    task automatic t_low_tone();
        int hi;
        @(posedge ref_clk);
        run <= 1'b1;
        hi = 0;
        repeat (12500) begin
            tick(1);
            if (freqDetect !== 1'b0 || pumpEnable !== 1'b0) hi++;
        end
        check("low_tone_quiet", hi, 0);
    endtask
    task automatic t_stop_after();
        @(posedge ref_clk);
        run <= 1'b0;
        wait_det(1'b0, 4000);
        tick(1);
        check("pump_drop", pumpEnable, 1'b0);
    endtask
    // Drop before expiry; the next run must wait the whole delay again
    task automatic t_stop_before();
        int hi;
        @(posedge ref_clk);
        run <= 1'b1;
        wait_det(1'b1, 6000);
        @(posedge ref_clk);
        run <= 1'b0;
        hi = 0;
        repeat (DLY + 200) begin
            tick(1);
            if (pumpEnable !== 1'b0) hi++;
        end
        check("early_pump", hi, 0);
        @(posedge ref_clk);
        run <= 1'b1;
        measure_delay();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(10);
        check("reset_detect", freqDetect, 1'b0);
        check("reset_pump", pumpEnable, 1'b0);
        @(posedge ref_clk);
        rst <= 1'b0;
        t_low_tone();
        @(posedge ref_clk);
        halfCycles <= 16'h04E2;
        measure_delay();
        t_stop_after();
        t_stop_before();
        conclude();
    end
endmodule
`default_nettype wire
